//--- boundary_scan_test_port.sv
`timescale 1ns/10ps
// How it works
// R01: TMS sampled at each TCK rising edge steps the controller state.
// R02: TDI is captured at each TCK rising edge.
// R03: Captured TDI goes to instruction or data register per current shift state.
// R04: TDO changes on TCK falling edges, from instruction or selected data register.
// R05: TDO driver is enabled only while shifting, high impedance otherwise.
// R06: Test logic steps only on TCK edges and never touches core function unasked.
// R07: Test reset clears controller and instruction register regardless of TCK.
// R08: Instruction register is two bits wide, public instructions only.
// R09: Instruction bits shift in only in Shift-IR.
// R10: Instruction decode selects the data register between TDI and TDO.
// R11: Two data registers exist: boundary-scan and bypass.
// R12: Bypass is one flip-flop, a one-bit TDI to TDO delay.
// R13: Boundary cells form one serial chain around the core pins.
// R14: Cell 0 is the first bit shifted out on TDO.
// R15: Output-enable cells are active high; one enables the driver.
// R16: Boundary chain holds cells 0 to 167, 168 in total.
// R17: Standard sixteen-state controller; five TMS ones reach Test-Logic-Reset.
// R18: All-ones code selects bypass; bypass is loaded on reset.
module boundary_scan_test_port (
    input  wire logic                                 i_core_clk,
    input  wire logic                                 i_reset_n,
    input  wire scan_port_pkg::test_pins_t            i_pins,
    input  wire logic [scan_port_pkg::BSR_LEN-1:0]    i_bsr_capture,
    output logic                                      o_tdo,
    output logic                                      o_tdo_oe,
    output logic [scan_port_pkg::BSR_LEN-1:0]         o_bsr_update,
    output logic                                      o_extest
);

    // Pin sampling into the core clock domain
    scan_port_pkg::test_pins_t pins_s;
    logic [scan_port_pkg::PIN_COUNT-1:0] pins_s_bits;

    pin_sync #(
        .WIDTH (scan_port_pkg::PIN_COUNT)
    ) u_pin_sync (
        .i_core_clk (i_core_clk),
        .i_reset_n  (i_reset_n),
        .i_async    (i_pins),
        .o_sync     (pins_s_bits)
    );

    assign pins_s = scan_port_pkg::test_pins_t'(pins_s_bits);

    // State and registers
    scan_port_pkg::tap_state_t                  state_ff;
    scan_port_pkg::tap_state_t                  nxt_state;
    logic                                       tck_prev_ff;
    logic [scan_port_pkg::IR_WIDTH-1:0]         ir_sr_ff;
    logic [scan_port_pkg::IR_WIDTH-1:0]         ir_ff;
    logic                                       bypass_ff;
    logic [scan_port_pkg::BSR_LEN-1:0]          bsr_sr_ff;
    logic [scan_port_pkg::BSR_LEN-1:0]          bsr_upd_ff;
    logic                                       tdo_ff;
    logic                                       tdo_oe_ff;
    logic                                       extest_ff;

    // Edge finding on the sampled test clock; TCK is never used as a clock
    wire tck_rise = pins_s.tck & ~tck_prev_ff; // R06
    wire tck_fall = ~pins_s.tck & tck_prev_ff;
    wire trst_hit = ~pins_s.trst_n;

    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            tck_prev_ff <= 1'b1;
        end else begin
            tck_prev_ff <= pins_s.tck;
        end
    end

    // State decode
    wire in_reset  = (state_ff == scan_port_pkg::ST_RESET);
    wire in_sh_dr  = (state_ff == scan_port_pkg::ST_SH_DR);
    wire in_sh_ir  = (state_ff == scan_port_pkg::ST_SH_IR);
    wire in_cap_dr = (state_ff == scan_port_pkg::ST_CAP_DR);
    wire in_cap_ir = (state_ff == scan_port_pkg::ST_CAP_IR);
    wire in_upd_dr = (state_ff == scan_port_pkg::ST_UPD_DR);
    wire in_upd_ir = (state_ff == scan_port_pkg::ST_UPD_IR);
    wire shifting  = in_sh_dr | in_sh_ir;

    // Instruction decode: boundary chain for the two boundary codes, bypass otherwise
    wire sel_bsr    = (ir_ff == scan_port_pkg::IR_EXTEST) | (ir_ff == scan_port_pkg::IR_SAMPLE); // R10
    wire sel_bypass = ~sel_bsr; // R18
    wire dr_serial  = sel_bsr ? bsr_sr_ff[0] : bypass_ff; // R14
    wire serial_out = in_sh_ir ? ir_sr_ff[0] : dr_serial; // R04

    // Next state of the sixteen-state controller
    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            scan_port_pkg::ST_RESET:  nxt_state = pins_s.tms ? scan_port_pkg::ST_RESET  : scan_port_pkg::ST_IDLE;
            scan_port_pkg::ST_IDLE:   nxt_state = pins_s.tms ? scan_port_pkg::ST_SEL_DR : scan_port_pkg::ST_IDLE;
            scan_port_pkg::ST_SEL_DR: nxt_state = pins_s.tms ? scan_port_pkg::ST_SEL_IR : scan_port_pkg::ST_CAP_DR;
            scan_port_pkg::ST_CAP_DR: nxt_state = pins_s.tms ? scan_port_pkg::ST_EX1_DR : scan_port_pkg::ST_SH_DR;
            scan_port_pkg::ST_SH_DR:  nxt_state = pins_s.tms ? scan_port_pkg::ST_EX1_DR : scan_port_pkg::ST_SH_DR;
            scan_port_pkg::ST_EX1_DR: nxt_state = pins_s.tms ? scan_port_pkg::ST_UPD_DR : scan_port_pkg::ST_PAU_DR;
            scan_port_pkg::ST_PAU_DR: nxt_state = pins_s.tms ? scan_port_pkg::ST_EX2_DR : scan_port_pkg::ST_PAU_DR;
            scan_port_pkg::ST_EX2_DR: nxt_state = pins_s.tms ? scan_port_pkg::ST_UPD_DR : scan_port_pkg::ST_SH_DR;
            scan_port_pkg::ST_UPD_DR: nxt_state = pins_s.tms ? scan_port_pkg::ST_SEL_DR : scan_port_pkg::ST_IDLE;
            scan_port_pkg::ST_SEL_IR: nxt_state = pins_s.tms ? scan_port_pkg::ST_RESET  : scan_port_pkg::ST_CAP_IR;
            scan_port_pkg::ST_CAP_IR: nxt_state = pins_s.tms ? scan_port_pkg::ST_EX1_IR : scan_port_pkg::ST_SH_IR;
            scan_port_pkg::ST_SH_IR:  nxt_state = pins_s.tms ? scan_port_pkg::ST_EX1_IR : scan_port_pkg::ST_SH_IR;
            scan_port_pkg::ST_EX1_IR: nxt_state = pins_s.tms ? scan_port_pkg::ST_UPD_IR : scan_port_pkg::ST_PAU_IR;
            scan_port_pkg::ST_PAU_IR: nxt_state = pins_s.tms ? scan_port_pkg::ST_EX2_IR : scan_port_pkg::ST_PAU_IR;
            scan_port_pkg::ST_EX2_IR: nxt_state = pins_s.tms ? scan_port_pkg::ST_UPD_IR : scan_port_pkg::ST_SH_IR;
            scan_port_pkg::ST_UPD_IR: nxt_state = pins_s.tms ? scan_port_pkg::ST_SEL_DR : scan_port_pkg::ST_IDLE;
        endcase
    end

    // Controller steps on TCK rise; test reset is a level, so it acts with TCK stopped
    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            state_ff <= scan_port_pkg::ST_RESET;
        end else if (trst_hit) begin
            state_ff <= scan_port_pkg::ST_RESET; // R07
        end else if (tck_rise) begin
            state_ff <= nxt_state; // R01 R17
        end
    end

    // Instruction shifter: capture pattern, then TDI enters at the top in Shift-IR
    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            ir_sr_ff <= scan_port_pkg::IR_BYPASS;
        end else if (tck_rise && in_cap_ir) begin
            ir_sr_ff <= scan_port_pkg::IR_CAPTURE;
        end else if (tck_rise && in_sh_ir) begin
            ir_sr_ff <= {pins_s.tdi, ir_sr_ff[1]}; // R02 R03 R09
        end
    end

    // Current instruction: loaded at Update-IR on the falling edge, bypass in reset
    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            ir_ff <= scan_port_pkg::IR_BYPASS;
        end else if (trst_hit || in_reset) begin
            ir_ff <= scan_port_pkg::IR_BYPASS; // R07 R18
        end else if (tck_fall && in_upd_ir) begin
            ir_ff <= ir_sr_ff; // R08
        end
    end

    // Bypass stage: zero at capture, one TDI bit delay in shift
    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            bypass_ff <= 1'b0;
        end else if (tck_rise && sel_bypass && in_cap_dr) begin
            bypass_ff <= 1'b0;
        end else if (tck_rise && sel_bypass && in_sh_dr) begin
            bypass_ff <= pins_s.tdi; // R03 R11 R12
        end
    end

    // Boundary chain: parallel capture, then shift toward cell 0
    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            bsr_sr_ff <= '0;
        end else if (tck_rise && sel_bsr && in_cap_dr) begin
            bsr_sr_ff <= i_bsr_capture; // R13
        end else if (tck_rise && sel_bsr && in_sh_dr) begin
            bsr_sr_ff <= {pins_s.tdi, bsr_sr_ff[scan_port_pkg::BSR_LEN-1:1]}; // R16 R14
        end
    end

    // Update latches hold still during shifting so the pins never ripple
    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            bsr_upd_ff <= scan_port_pkg::BSR_UPD_RESET;
        end else if (trst_hit) begin
            bsr_upd_ff <= scan_port_pkg::BSR_UPD_RESET;
        end else if (tck_fall && sel_bsr && in_upd_dr) begin
            bsr_upd_ff <= bsr_sr_ff; // R15
        end
    end

    // Core keeps its own pins until the boundary test instruction is current
    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            extest_ff <= 1'b0;
        end else begin
            extest_ff <= (ir_ff == scan_port_pkg::IR_EXTEST) & ~in_reset; // R06
        end
    end

    // Output stage changes only on TCK fall or test reset, so data is steady at the far rise
    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            tdo_ff    <= 1'b0;
            tdo_oe_ff <= 1'b0;
        end else if (trst_hit) begin
            tdo_oe_ff <= 1'b0;
        end else if (tck_fall) begin
            tdo_ff    <= serial_out; // R04
            tdo_oe_ff <= shifting; // R05
        end
    end

    assign o_tdo        = tdo_ff;
    assign o_tdo_oe     = tdo_oe_ff;
    assign o_bsr_update = bsr_upd_ff;
    assign o_extest     = extest_ff;

    // Helper: run of TMS ones seen at TCK rises
    logic [2:0] ones_run_ff;
    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            ones_run_ff <= 3'h0;
        end else if (tck_rise) begin
            ones_run_ff <= !pins_s.tms ? 3'h0 : (ones_run_ff == 3'h7 ? 3'h7 : ones_run_ff + 3'h1);
        end
    end

    property p_five_ones;
        @(posedge i_core_clk) disable iff (!i_reset_n)
        (ones_run_ff >= scan_port_pkg::TLR_ONES) |-> in_reset;
    endproperty
    a_five_ones: assert property (p_five_ones) else $error("five TMS ones did not reach reset"); // R17

    property p_trst;
        @(posedge i_core_clk) disable iff (!i_reset_n)
        trst_hit |=> in_reset && (ir_ff == scan_port_pkg::IR_BYPASS) && !o_tdo_oe;
    endproperty
    a_trst: assert property (p_trst) else $error("test reset left state or instruction"); // R07

    property p_step_on_rise;
        @(posedge i_core_clk) disable iff (!i_reset_n)
        !tck_rise && !trst_hit |=> $stable(state_ff);
    endproperty
    a_step_on_rise: assert property (p_step_on_rise) else $error("state moved without TCK rise"); // R01

    property p_oe_shift;
        @(posedge i_core_clk) disable iff (!i_reset_n)
        tck_fall && !trst_hit |=> (o_tdo_oe == $past(shifting));
    endproperty
    a_oe_shift: assert property (p_oe_shift) else $error("TDO enable not tied to shifting"); // R05

    property p_tdo_fall_only;
        @(posedge i_core_clk) disable iff (!i_reset_n)
        !tck_fall |=> $stable(o_tdo);
    endproperty
    a_tdo_fall_only: assert property (p_tdo_fall_only) else $error("TDO changed off a falling edge"); // R04

    property p_bsr_first;
        @(posedge i_core_clk) disable iff (!i_reset_n)
        tck_fall && in_sh_dr && sel_bsr && !trst_hit |=> o_tdo == $past(bsr_sr_ff[0]);
    endproperty
    a_bsr_first: assert property (p_bsr_first) else $error("boundary cell 0 not on TDO"); // R14

    property p_bypass_delay;
        @(posedge i_core_clk) disable iff (!i_reset_n)
        tck_rise && in_sh_dr && sel_bypass && !trst_hit |=> bypass_ff == $past(pins_s.tdi);
    endproperty
    a_bypass_delay: assert property (p_bypass_delay) else $error("bypass stage missed TDI"); // R12

    property p_ir_shift_only;
        @(posedge i_core_clk) disable iff (!i_reset_n)
        tck_rise && !in_sh_ir && !in_cap_ir |=> $stable(ir_sr_ff);
    endproperty
    a_ir_shift_only: assert property (p_ir_shift_only) else $error("instruction shifter moved off Shift-IR"); // R09

    property p_ir_enter;
        @(posedge i_core_clk) disable iff (!i_reset_n)
        tck_rise && in_sh_ir && !trst_hit |=> ir_sr_ff[1] == $past(pins_s.tdi);
    endproperty
    a_ir_enter: assert property (p_ir_enter) else $error("TDI bit not taken into instruction"); // R02

    c_ir_scan:   cover property (@(posedge i_core_clk) disable iff (!i_reset_n) tck_fall && in_upd_ir);
    c_bsr_shift: cover property (@(posedge i_core_clk) disable iff (!i_reset_n) tck_rise && in_sh_dr && sel_bsr);
    c_bypass:    cover property (@(posedge i_core_clk) disable iff (!i_reset_n) tck_rise && in_sh_dr && sel_bypass);
    c_trst:      cover property (@(posedge i_core_clk) disable iff (!i_reset_n) trst_hit && !in_reset);

endmodule

//--- boundary_scan_test_port_tb.sv
`timescale 1ns/10ps
module boundary_scan_test_port_tb;
    localparam int unsigned N = scan_port_pkg::BSR_LEN;
    logic                      i_core_clk;
    logic                      i_reset_n;
    scan_port_pkg::test_pins_t pins;
    logic [N-1:0]              i_bsr_capture;
    logic                      o_tdo;
    logic                      o_tdo_oe;
    logic                      o_extest;
    logic [N-1:0]              o_bsr_update;
    logic [N-1:0]              prev;
    logic [255:0]              din;
    logic [255:0]              dout;
    logic [31:0]               seed;
    logic                      t;
    logic                      oe;
    logic                      chain;
    int                        n_errors;
    int                        checked;
    int                        cycles;

    boundary_scan_test_port dut (
        .i_core_clk    (i_core_clk),
        .i_reset_n     (i_reset_n),
        .i_pins        (pins),
        .i_bsr_capture (i_bsr_capture),
        .o_tdo         (o_tdo),
        .o_tdo_oe      (o_tdo_oe),
        .o_bsr_update  (o_bsr_update),
        .o_extest      (o_extest)
    );

    scan_master_model ctl (
        .i_core_clk (i_core_clk),
        .i_tdo      (o_tdo),
        .i_tdo_oe   (o_tdo_oe),
        .o_pins     (pins)
    );

    always #25 i_core_clk = ~i_core_clk;

    // Hang guard, well above the roughly 10400 cycles the sequence needs
    always @(posedge i_core_clk) begin
        cycles++;
        if (cycles == 40000) begin
            n_errors++;
            complete_run();
        end
    end

    task automatic complete_run();
        $display("checks %0d mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [255:0] got, input logic [255:0] exp);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        x = x ^ (x << 5);
        return x;
    endfunction

    task automatic rnd(output logic [255:0] v);
        for (int k = 0; k < 8; k++) begin
            seed = xs(seed);
            v[k*32 +: 32] = seed;
        end
    endtask

    // Chain shows capture cells 0 to N-1 first, then the first TDI bit; bypass shows 0 then TDI delayed one
    function automatic logic [255:0] exp_dr(input logic ch, input logic [255:0] d, input logic [N-1:0] cap);
        logic [255:0] e;
        e = '0;
        if (ch) begin
            e[N-1:0] = cap;
            e[N] = d[0];
        end else begin
            e[N:1] = d[N-1:0];
        end
        return e;
    endfunction

    // Full scan from Idle back to Idle; one extra Idle cycle confirms the driver is released
    task automatic scan(input logic is_ir, input int n, input logic [255:0] d, output logic [255:0] q);
        q = '0;
        ctl.tck_cycle(1'b1, 1'b0, t, oe);
        if (is_ir) begin
            ctl.tck_cycle(1'b1, 1'b0, t, oe);
        end
        ctl.tck_cycle(1'b0, 1'b0, t, oe);
        ctl.tck_cycle(1'b0, 1'b0, t, oe);
        for (int i = 0; i < n; i++) begin
            ctl.tck_cycle(i == n - 1, d[i], t, oe);
            q[i] = t;
            chk(oe, 1'b1);
        end
        ctl.tck_cycle(1'b1, 1'b0, t, oe);
        ctl.tck_cycle(1'b0, 1'b0, t, oe);
        ctl.tck_cycle(1'b0, 1'b0, t, oe);
        chk(oe, 1'b0);
    endtask

    task automatic bypass_check();
        rnd(din);
        scan(1'b0, N + 1, din, dout);
        chk(dout, exp_dr(1'b0, din, i_bsr_capture));
    endtask

    initial begin
        i_core_clk = 1'b0;
        i_reset_n = 1'b0;
        i_bsr_capture = '0;
        seed = 32'h34;
        n_errors = 0;
        checked = 0;
        cycles = 0;
        repeat (20) @(posedge i_core_clk);
        i_reset_n <= 1'b1;
        repeat (4) @(posedge i_core_clk);
        #1;
        chk({o_tdo_oe, o_extest, o_bsr_update}, '0);
        ctl.tck_cycle(1'b0, 1'b0, t, oe);
        bypass_check();
        $display("test reset_bypass done");
        // Every instruction code, each followed by a scan one bit longer than the chain
        for (int c = 0; c < 4; c++) begin
            rnd(din);
            @(posedge i_core_clk);
            i_bsr_capture <= din[N-1:0];
            scan(1'b1, 2, 256'(c), dout);
            chk(dout[1:0], scan_port_pkg::IR_CAPTURE);
            chk(o_extest, 2'(c) == scan_port_pkg::IR_EXTEST);
            chain = (2'(c) == scan_port_pkg::IR_EXTEST) || (2'(c) == scan_port_pkg::IR_SAMPLE);
            prev = o_bsr_update;
            rnd(din);
            scan(1'b0, N + 1, din, dout);
            chk(dout, exp_dr(chain, din, i_bsr_capture));
            chk(o_bsr_update, chain ? din[N:1] : prev);
        end
        $display("test instructions done");
        // Test reset in mid Shift-DR under EXTEST, with TCK standing still
        scan(1'b1, 2, 256'(scan_port_pkg::IR_EXTEST), dout);
        ctl.tck_cycle(1'b1, 1'b0, t, oe);
        ctl.tck_cycle(1'b0, 1'b0, t, oe);
        ctl.tck_cycle(1'b0, 1'b0, t, oe);
        ctl.tck_cycle(1'b0, 1'b1, t, oe);
        chk({oe, o_extest}, 2'h3);
        ctl.set_trst_n(1'b0);
        chk({o_tdo_oe, o_extest, o_bsr_update}, '0);
        ctl.set_trst_n(1'b1);
        ctl.tck_cycle(1'b0, 1'b0, t, oe);
        bypass_check();
        $display("test trst done");
        // Five TMS ones from Idle leave EXTEST behind
        scan(1'b1, 2, 256'(scan_port_pkg::IR_EXTEST), dout);
        chk(o_extest, 1'b1);
        for (int k = 0; k < 5; k++) begin
            ctl.tck_cycle(1'b1, 1'b0, t, oe);
        end
        chk({oe, o_extest}, 2'h0);
        ctl.tck_cycle(1'b0, 1'b0, t, oe);
        bypass_check();
        $display("test five_ones done");
        complete_run();
    end
endmodule

//--- pin_sync.sv
`timescale 1ns/10ps
module pin_sync #(
    parameter int unsigned WIDTH = 4
) (
    input  wire logic             i_core_clk,
    input  wire logic             i_reset_n,
    input  wire logic [WIDTH-1:0] i_async,
    output logic      [WIDTH-1:0] o_sync
);

    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] sync_ff;

    // Two stages; the first is read only by the second
    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            meta_ff <= '1;
            sync_ff <= '1;
        end else begin
            meta_ff <= i_async;
            sync_ff <= meta_ff;
        end
    end

    assign o_sync = sync_ff;

endmodule

//--- scan_master_model.sv
`timescale 1ns/10ps
module scan_master_model (
    input  wire logic                 i_core_clk,
    input  wire logic                 i_tdo,
    input  wire logic                 i_tdo_oe,
    output scan_port_pkg::test_pins_t o_pins
);
    logic tdo_last;
    logic tdo_line;

    // A released TDO shows the inverse of its last value, so a stale bit never passes
    assign tdo_line = i_tdo_oe ? i_tdo : ~tdo_last;

    always @(posedge i_core_clk) begin
        if (i_tdo_oe === 1'b1) begin
            tdo_last <= i_tdo;
        end
    end

    // TCK rests high between frames, matching the synchroniser's reset level
    initial begin
        o_pins = '{tck: 1'b1, tms: 1'b1, tdi: 1'b1, trst_n: 1'b1};
        tdo_last = 1'b0;
    end

    // One TCK period is 8 core cycles; TMS and TDI change with the fall, 4 cycles before the rise
    task automatic tck_cycle(input logic tms, input logic tdi, output logic tdo, output logic oe);
        @(posedge i_core_clk);
        o_pins.tck <= 1'b0;
        o_pins.tms <= tms;
        o_pins.tdi <= tdi;
        repeat (4) @(posedge i_core_clk);
        o_pins.tck <= 1'b1;
        // TDO from the last fall stands until the next one, so sample in the high phase
        repeat (3) @(posedge i_core_clk);
        #1;
        tdo = tdo_line;
        oe = i_tdo_oe;
    endtask

    // Test reset level, held long enough for the synchroniser
    task automatic set_trst_n(input logic v);
        @(posedge i_core_clk);
        o_pins.trst_n <= v;
        repeat (5) @(posedge i_core_clk);
        #1;
    endtask
endmodule

//--- scan_port_pkg.sv
package scan_port_pkg;

    // Chain and instruction geometry
    localparam int unsigned BSR_LEN   = 168;
    localparam int unsigned IR_WIDTH  = 2;
    localparam int unsigned PIN_COUNT = 4;

    // Instruction codes; the all-ones code is bypass
    localparam logic [1:0] IR_EXTEST  = 2'h0;
    localparam logic [1:0] IR_SAMPLE  = 2'h1;
    localparam logic [1:0] IR_SPARE   = 2'h2;
    localparam logic [1:0] IR_BYPASS  = 2'h3;
    // Fixed pattern loaded into the instruction shifter at Capture-IR
    localparam logic [1:0] IR_CAPTURE = 2'h1;

    // Reset value of the boundary update latches: all drivers disabled
    localparam logic [BSR_LEN-1:0] BSR_UPD_RESET = '0;

    // Consecutive TMS ones that always reach Test-Logic-Reset
    localparam logic [2:0] TLR_ONES = 3'h5;

    // Test pins as seen from outside, sampled by the core clock
    typedef struct packed {
        logic tck;
        logic tms;
        logic tdi;
        logic trst_n;
    } test_pins_t;

    // Controller states, Gray coded along the data-register path
    typedef enum logic [3:0] {
        ST_RESET   = 4'h0,
        ST_IDLE    = 4'h1,
        ST_SEL_DR  = 4'h3,
        ST_CAP_DR  = 4'h2,
        ST_SH_DR   = 4'h6,
        ST_EX1_DR  = 4'h7,
        ST_PAU_DR  = 4'h5,
        ST_EX2_DR  = 4'h4,
        ST_UPD_DR  = 4'hC,
        ST_SEL_IR  = 4'hD,
        ST_CAP_IR  = 4'hF,
        ST_SH_IR   = 4'hE,
        ST_EX1_IR  = 4'hA,
        ST_PAU_IR  = 4'hB,
        ST_EX2_IR  = 4'h9,
        ST_UPD_IR  = 4'h8
    } tap_state_t;

endpackage
